// File: dv/remote_sampler.sv
// Far-side model: a remote module that sends one I/O sample per call of send.
// Assumes the bench calls send from its main sequence; fields move on falling edges only.
`timescale 1ns/1ps
`default_nettype none

module remote_sampler (
	// Clock
	input wire logic i_clk,
	// Sample toward the block
	output var io_pass_pkg::rx_sample_t o_rx
);
	initial o_rx = '0;

	// Fields carry nothing after the valid cycle, so they are scrambled rather than held
	task automatic send(input logic [15:0] src, input logic [13:0] dmask,
		input logic [13:0] dval, input logic [1:0] amask, input logic [9:0] a);
		@(negedge i_clk);
		o_rx <= {1'b1, src, dmask, dval, amask, a, ~a};
		@(negedge i_clk);
		o_rx <= {1'b0, ~src, ~dmask, ~dval, ~amask, ~a, a};
	endtask : send
endmodule : remote_sampler

`default_nettype wire

// File: dv/tb_io_change_detect_line_passing.sv
// Self-checking bench for change detection and line passing.
// Assumes the design package is compiled first and remote_sampler models the far side.
`timescale 1ns/1ps
`default_nettype none

module tb_io_change_detect_line_passing;
	localparam int MSC = 4;
	localparam int TICK = MSC * 100;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	io_pass_pkg::cfg_t cfg = '0;
	logic ovr_wr = 1'b0;
	logic [7:0] ovr_level = 8'h00;
	logic [13:0] line_in = 14'h0000;
	logic sleep = 1'b0;
	io_pass_pkg::periph_t periph = 7'h70;
	io_pass_pkg::rx_sample_t rx;
	logic [13:0] line_out, line_oe, pull_en, pull_up;
	io_pass_pkg::periph_t periph_o;
	io_pass_pkg::tx_req_t tx;
	logic pwm_a, pwm_b, emit, last_flush = 1'b0, chg_prev_flush = 1'b0;
	logic [15:0] n_emit = 16'h0000, n_chg = 16'h0000, n_take = 16'h0000, n_flush = 16'h0000;
	logic [15:0] n_pa = 16'h0000, n_pb = 16'h0000;
	logic [15:0] b_emit, b_chg, b_take, b_flush, b_pa, b_pb;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #10 i_clk = ~i_clk;

	remote_sampler partner (.i_clk(i_clk), .o_rx(rx));

	io_change_detect_line_passing #(.P_MS_CYCLES(MSC)) DUT (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg(cfg), .i_ovr_wr(ovr_wr),
		.i_ovr_level(ovr_level), .i_line_in(line_in), .i_sleep(sleep), .i_periph(periph),
		.i_rx(rx), .o_line_out(line_out), .o_line_oe(line_oe), .o_pull_en(pull_en),
		.o_pull_up(pull_up),
		.o_periph(periph_o), .o_pwm_a(pwm_a), .o_pwm_b(pwm_b), .o_tx(tx), .o_emit(emit));

	// ****************************************
	// Monitors and helpers
	// ****************************************
	// Sampled mid-cycle so pulses launched on a rising edge are settled
	always @(negedge i_clk) begin
		n_emit <= n_emit + emit;
		n_chg <= n_chg + tx.change;
		n_take <= n_take + tx.take;
		n_flush <= n_flush + tx.flush;
		n_pa <= n_pa + pwm_a;
		n_pb <= n_pb + pwm_b;
		last_flush <= tx.flush;
		if (tx.change) chg_prev_flush <= last_flush;
	end

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// Hang guard, generous against the few thousand cycles the tests need
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cycles(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cycles

	task automatic snap;
		{b_emit, b_chg, b_take, b_flush, b_pa, b_pb} = {n_emit, n_chg, n_take, n_flush, n_pa, n_pb};
	endtask : snap

	task automatic toggle(input int i);
		line_in[i] = ~line_in[i];
		cycles(8);
	endtask : toggle

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		cfg.line_mode[1] = io_pass_pkg::MODE_DOUT_LO;
		cfg.line_mode[2] = io_pass_pkg::MODE_DOUT_LO;
		cfg.line_mode[3] = io_pass_pkg::MODE_DIN;
		cfg.line_mode[4] = io_pass_pkg::MODE_DOUT_HI;
		cfg.pull_resistor_enable = 14'h0008;
		cfg.pull_direction = 14'h0008;
		cfg.line_mode[5] = io_pass_pkg::MODE_DIN;
		cfg.change_watch_mask = 14'h0062;
		cfg.samples_per_packet = io_pass_pkg::SPP_SINGLE;
		cfg.line_pass_source_addr = 16'h1234;
		cfg.matched_frame_emit_enable = 1'b1;
		cfg.api_mode = 1'b1;
		cfg.pwm_pass_timeout = 8'h05;
		cfg.digital_pass_timeout[2] = 8'h02;
		cycles(16);
		i_rstn = 1'b1;
		cycles(4);
		check(line_oe, 32'h16);
		snap();
		partner.send(16'h4321, 14'h0004, 14'h0004, 2'b00, 10'h000);
		cycles(3);
		check(line_out, 32'h10);
		check(n_emit - b_emit, 32'h1);
		partner.send(16'h1234, 14'h000c, 14'h000c, 2'b00, 10'h000);
		cycles(3);
		check(line_out & 14'h000c, 32'h4);
		cfg.matched_frame_emit_enable = 1'b0;
		snap();
		partner.send(16'h1234, 14'h0004, 14'h0004, 2'b00, 10'h000);
		cycles(3);
		check(n_emit - b_emit, 32'h0);
		cycles(TICK - 20);
		check(line_out[2], 32'h1);
		cycles(TICK + 40);
		check(line_out[2], 32'h0);
		cfg.line_pass_source_addr = io_pass_pkg::BCAST_ADDR;
		partner.send(16'h5555, 14'h0004, 14'h0004, 2'b00, 10'h000);
		cycles(3);
		check(line_out[2], 32'h1);
		cfg.api_mode = 1'b0;
		cfg.matched_frame_emit_enable = 1'b1;
		snap();
		partner.send(16'h1234, 14'h0004, 14'h0000, 2'b00, 10'h000);
		cycles(3);
		check(line_out[2], 32'h0);
		check(n_emit - b_emit, 32'h0);
		ovr_level = 8'h02;
		ovr_wr = 1'b1;
		cycles(1);
		ovr_wr = 1'b0;
		cycles(6);
		check(line_out[1], 32'h1);
		check(line_out[4], 32'h0);
		check(n_chg - b_chg, 32'h1);
		snap();
		toggle(5);
		check(n_chg - b_chg, 32'h1);
		toggle(6);
		check(n_chg - b_chg, 32'h1);
		cfg.periodic_sample_interval = 16'h0001;
		cycles(8);
		snap();
		cycles(40);
		check(n_take - b_take, 32'ha);
		check(n_flush - b_flush, 32'ha);
		cfg.samples_per_packet = 8'h10;
		cycles(20);
		cfg.periodic_sample_interval = io_pass_pkg::IVAL_OFF;
		cycles(4);
		snap();
		toggle(5);
		check(n_flush - b_flush, 32'h1);
		check({n_chg - b_chg, 15'h0000, chg_prev_flush}, 32'h10001);
		// Line 2 is passed here too so that it is still held when sleep starts
		cfg.digital_pass_timeout[2] = 8'h05;
		partner.send(16'h1234, 14'h0004, 14'h0004, 2'b01, 10'h3ff);
		cycles(4);
		snap();
		cycles(1024);
		check(n_pa - b_pa, 32'h3ff);
		check(n_pb - b_pb, 32'h0);
		sleep = 1'b1;
		cycles(6);
		check(periph_o, 32'h4f);
		check(pull_en, 32'h8);
		check(pull_up, 32'h8);
		snap();
		toggle(5);
		cycles(22);
		check(n_pa - b_pa, 32'h0);
		check(n_chg - b_chg, 32'h0);
		check(line_out[1], 32'h1);
		check(line_out[2], 32'h1);
		sleep = 1'b0;
		cycles(6);
		check(periph_o, 32'h70);
		snap();
		cycles(1024);
		check(n_pa - b_pa, 32'h0);
		cfg.pwm_pass_timeout = 8'h01;
		cfg.pwm_b_preset_duty = 10'h100;
		partner.send(16'h1234, 14'h0000, 14'h0000, 2'b11, 10'h200);
		cycles(420);
		snap();
		cycles(1024);
		check(n_pa - b_pa, 32'h0);
		check(n_pb - b_pb, 32'h100);
		test_done();
	end
endmodule : tb_io_change_detect_line_passing

`default_nettype wire

// File: logic/io_change_detect_line_passing.sv
// Change detection, periodic sample timing and digital/PWM line passing.
// Assumes i_rx and i_cfg come from logic on i_clk; i_line_in and i_sleep are asynchronous.
//
// Contract
// RULE1: Any watched line changing state requests an immediate sample.
// RULE2: Only digital input or output lines are watched for change.
// RULE3: No change detection while asleep.
// RULE4: With several samples per packet, flush collected samples before the change sample.
// RULE5: Only samples from the chosen source drive outputs.
// RULE6: Broadcast source address lets any sender drive outputs.
// RULE7: A sampled line drives the same-numbered local line only if it is output.
// RULE8: Each digital line has its own timeout back to its configured state.
// RULE9: Passing only on general lines up to the last pass line, never UART/SPI.
// RULE10: PWM A follows analog input A, PWM B follows analog input B.
// RULE11: One shared PWM timeout returns both channels to preset duty.
// RULE12: Line passing works in API and transparent mode alike.
// RULE13: In API mode frames are emitted; emit-enable 0 hides matching ones only.
// RULE14: Override word sets levels of lines 0..7 that are outputs, no timeout.
// RULE15: An override level change on a watched line counts as a change.
// RULE16: Asleep: outputs hold, pulls stay, peripheral lines low, SPI high. CTS is not forced low; it still follows i_periph.
// RULE17: Passed levels hold in sleep; line timers pause and resume on wake.
// RULE18: PWM low in sleep; on wake passed PWM returns to preset.
// RULE19: Periodic sample each interval in milliseconds; zero disables it.
// RULE20: Line passing timeouts count in 100 ms ticks.
`timescale 1ns/1ps
`default_nettype none

module io_change_detect_line_passing #(
	parameter int P_MS_CYCLES = io_pass_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Configuration and override
	input wire io_pass_pkg::cfg_t i_cfg,
	input wire logic i_ovr_wr,
	input wire logic [io_pass_pkg::OVR_LINES-1:0] i_ovr_level,
	// Pins and sleep state
	input wire logic [io_pass_pkg::NL-1:0] i_line_in,
	input wire logic i_sleep,
	input wire io_pass_pkg::periph_t i_periph,
	// Received samples
	input wire io_pass_pkg::rx_sample_t i_rx,
	// Line outputs
	output logic [io_pass_pkg::NL-1:0] o_line_out,
	output logic [io_pass_pkg::NL-1:0] o_line_oe,
	output logic [io_pass_pkg::NL-1:0] o_pull_en,
	output logic [io_pass_pkg::NL-1:0] o_pull_up,
	output io_pass_pkg::periph_t o_periph,
	output logic o_pwm_a,
	output logic o_pwm_b,
	// Sample requests and frame emit
	output io_pass_pkg::tx_req_t o_tx,
	output logic o_emit
);

	typedef struct packed {
		logic [io_pass_pkg::NL-1:0] pin_s1;
		logic [io_pass_pkg::NL-1:0] pin_s2;
		logic sleep_s1;
		logic sleep_s2;
		logic sleep_d;
		logic [io_pass_pkg::NL-1:0] watch_prev;
		logic [io_pass_pkg::OVR_LINES-1:0] ovr;
		logic [io_pass_pkg::OVR_LINES-1:0] ovr_set;
		logic [io_pass_pkg::NL-1:0] pass_act;
		logic [io_pass_pkg::NL-1:0] pass_val;
		logic [io_pass_pkg::NL-1:0][io_pass_pkg::TW-1:0] tmr;
		logic [1:0] pwm_act;
		logic [io_pass_pkg::DW-1:0] pwm_a_val;
		logic [io_pass_pkg::DW-1:0] pwm_b_val;
		logic [io_pass_pkg::TW-1:0] pwm_tmr;
		logic [io_pass_pkg::DW-1:0] pwm_cnt;
		logic [31:0] ms_cnt;
		logic [6:0] tick_cnt;
		logic [1:0] arm;
		logic [15:0] ival_cnt;
		logic [7:0] coll;
		io_pass_pkg::chg_state_t chg;
		logic [io_pass_pkg::NL-1:0] line_out;
		logic [io_pass_pkg::NL-1:0] line_oe;
		logic [io_pass_pkg::NL-1:0] pull_en;
		logic [io_pass_pkg::NL-1:0] pull_up;
		io_pass_pkg::periph_t periph;
		logic pwm_a;
		logic pwm_b;
		io_pass_pkg::tx_req_t tx;
		logic emit;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic is_out(input logic [2:0] m);
		is_out = (m == io_pass_pkg::MODE_DOUT_LO) || (m == io_pass_pkg::MODE_DOUT_HI);
	endfunction : is_out

	// *****************************************
	// Next state
	// *****************************************
	always_comb begin
		logic awake;
		logic wake;
		logic ms_tick;
		logic tick100;
		logic match;
		logic rx_apply;
		logic chg_any;
		logic lvl;
		logic watch;
		logic [io_pass_pkg::NL-1:0] ovr_set_w;
		logic [io_pass_pkg::NL-1:0] ovr_w;
		logic [io_pass_pkg::DW-1:0] duty_a;
		logic [io_pass_pkg::DW-1:0] duty_b;
		s_d = s_q;
		awake = !s_q.sleep_s2;
		wake = s_q.sleep_d && !s_q.sleep_s2;
		ms_tick = 1'b0;
		tick100 = 1'b0;
		chg_any = 1'b0;
		lvl = 1'b0;
		watch = 1'b0;
		match = 1'b0;
		rx_apply = 1'b0;
		duty_a = '0;
		duty_b = '0;
		ovr_set_w = {{(io_pass_pkg::NL-io_pass_pkg::OVR_LINES){1'b0}}, s_q.ovr_set};
		ovr_w = {{(io_pass_pkg::NL-io_pass_pkg::OVR_LINES){1'b0}}, s_q.ovr};
		s_d.tx = '0;
		s_d.pin_s1 = i_line_in;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.sleep_s1 = i_sleep;
		s_d.sleep_s2 = s_q.sleep_s1;
		s_d.sleep_d = s_q.sleep_s2;
		// Blind until synchronisers and first driven levels settle, else reset fakes an edge
		if (!(&s_q.arm)) begin
			s_d.arm = s_q.arm + 2'h1;
		end
		// Time base stops while asleep so pass timers are suspended
		if (awake) begin // [RULE17]
			if (s_q.ms_cnt == 32'(P_MS_CYCLES - 1)) begin
				s_d.ms_cnt = '0;
				ms_tick = 1'b1;
			end else begin
				s_d.ms_cnt = s_q.ms_cnt + 32'h1;
			end
		end
		if (ms_tick) begin
			if (s_q.tick_cnt == 7'(io_pass_pkg::TICK_MS - 1)) begin // [RULE20]
				s_d.tick_cnt = '0;
				tick100 = 1'b1;
			end else begin
				s_d.tick_cnt = s_q.tick_cnt + 7'h1;
			end
		end
		// Source filter; serial mode plays no part in passing
		match = i_rx.valid && ((i_cfg.line_pass_source_addr == io_pass_pkg::BCAST_ADDR) // [RULE6]
			|| (i_cfg.line_pass_source_addr == i_rx.src)); // [RULE5] [RULE12]
		rx_apply = match && awake;
		s_d.emit = i_rx.valid && i_cfg.api_mode && (!match || i_cfg.matched_frame_emit_enable); // [RULE13]
		if (i_ovr_wr) begin // [RULE14]
			s_d.ovr = i_ovr_level;
			s_d.ovr_set = '1;
		end
		for (int i = 0; i < io_pass_pkg::NL; i++) begin
			if (rx_apply && io_pass_pkg::PASS_LINES[i] && is_out(i_cfg.line_mode[i])
				&& i_rx.dmask[i]) begin // [RULE7] [RULE9]
				s_d.pass_act[i] = 1'b1;
				s_d.pass_val[i] = i_rx.dval[i];
				s_d.tmr[i] = i_cfg.digital_pass_timeout[i];
			end else if (s_q.pass_act[i] && tick100) begin // [RULE8]
				if (s_q.tmr[i] <= 8'h01) begin
					s_d.pass_act[i] = 1'b0;
				end else begin
					s_d.tmr[i] = s_q.tmr[i] - 8'h01;
				end
			end
			if (!is_out(i_cfg.line_mode[i])) begin
				s_d.pass_act[i] = 1'b0;
			end
			lvl = s_q.pass_act[i] ? s_q.pass_val[i]
				: ovr_set_w[i] ? ovr_w[i] // [RULE14]
				: (i_cfg.line_mode[i] == io_pass_pkg::MODE_DOUT_HI);
			s_d.line_out[i] = is_out(i_cfg.line_mode[i]) && lvl;
			s_d.line_oe[i] = is_out(i_cfg.line_mode[i]);
			// Outputs are watched on their driven level, so override edges count too
			watch = (i_cfg.line_mode[i] == io_pass_pkg::MODE_DIN) ? s_q.pin_s2[i]
				: s_q.line_out[i]; // [RULE15]
			s_d.watch_prev[i] = watch;
			// Tracking continues in sleep so a sleep-time transition is never seen
			if (awake && (&s_q.arm) && i_cfg.change_watch_mask[i] && watch != s_q.watch_prev[i]
				&& (i_cfg.line_mode[i] == io_pass_pkg::MODE_DIN
				|| is_out(i_cfg.line_mode[i]))) begin // [RULE1] [RULE2] [RULE3]
				chg_any = 1'b1;
			end
		end
		// Periodic sampling
		if (ms_tick && i_cfg.periodic_sample_interval != io_pass_pkg::IVAL_OFF) begin // [RULE19]
			if (s_q.ival_cnt >= i_cfg.periodic_sample_interval - 16'h1) begin
				s_d.ival_cnt = '0;
				s_d.tx.take = 1'b1;
				if (s_q.coll + 8'h1 >= i_cfg.samples_per_packet) begin
					s_d.tx.flush = 1'b1;
					s_d.coll = '0;
				end else begin
					s_d.coll = s_q.coll + 8'h1;
				end
			end else begin
				s_d.ival_cnt = s_q.ival_cnt + 16'h1;
			end
		end
		case (s_q.chg)
			io_pass_pkg::CHG_IDLE: begin
				if (chg_any) begin
					if (i_cfg.samples_per_packet > io_pass_pkg::SPP_SINGLE
						&& s_q.coll != 8'h0) begin // [RULE4]
						s_d.tx.flush = 1'b1;
						s_d.coll = '0;
						s_d.chg = io_pass_pkg::CHG_PEND;
					end else begin
						s_d.tx.change = 1'b1;
					end
				end
			end
			io_pass_pkg::CHG_PEND: begin
				s_d.tx.change = 1'b1; // [RULE4]
				s_d.chg = io_pass_pkg::CHG_IDLE;
			end
			default: s_d.chg = io_pass_pkg::CHG_IDLE;
		endcase
		// Analog passing with one shared timer
		if (rx_apply && i_rx.amask != 2'b00) begin // [RULE10] [RULE11]
			s_d.pwm_tmr = i_cfg.pwm_pass_timeout;
			if (i_rx.amask[0]) begin
				s_d.pwm_act[0] = 1'b1;
				s_d.pwm_a_val = i_rx.analog_input_a;
			end
			if (i_rx.amask[1]) begin
				s_d.pwm_act[1] = 1'b1;
				s_d.pwm_b_val = i_rx.analog_input_b;
			end
		end else if (s_q.pwm_act != 2'b00 && tick100) begin
			if (s_q.pwm_tmr <= 8'h01) begin
				s_d.pwm_act = 2'b00; // [RULE11]
			end else begin
				s_d.pwm_tmr = s_q.pwm_tmr - 8'h01;
			end
		end
		if (wake) begin
			s_d.pwm_act = 2'b00; // [RULE18]
		end
		duty_a = s_q.pwm_act[0] ? s_q.pwm_a_val : i_cfg.pwm_a_preset_duty;
		duty_b = s_q.pwm_act[1] ? s_q.pwm_b_val : i_cfg.pwm_b_preset_duty;
		s_d.pwm_cnt = s_q.pwm_cnt + 10'h001;
		s_d.pwm_a = awake && (s_q.pwm_cnt < duty_a); // [RULE18]
		s_d.pwm_b = awake && (s_q.pwm_cnt < duty_b);
		// Sleep pin states
		s_d.pull_en = i_cfg.pull_resistor_enable; // [RULE16]
		s_d.pull_up = i_cfg.pull_direction;
		s_d.periph.cts = i_periph.cts;
		s_d.periph.other = awake ? i_periph.other : 2'b00; // [RULE16]
		s_d.periph.spi = awake ? i_periph.spi : 4'hf;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_line_out = s_q.line_out;
	assign o_line_oe = s_q.line_oe;
	assign o_pull_en = s_q.pull_en;
	assign o_pull_up = s_q.pull_up;
	assign o_periph = s_q.periph;
	assign o_pwm_a = s_q.pwm_a;
	assign o_pwm_b = s_q.pwm_b;
	assign o_tx = s_q.tx;
	assign o_emit = s_q.emit;

	// *****************************************
	// Checks
	// *****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	AST_NO_CHG_ASLEEP: assert property (s_q.sleep_s2 && s_q.sleep_d && s_q.chg == io_pass_pkg::CHG_IDLE
		|=> !s_q.tx.change) else $error("change sample while asleep"); // [RULE3]
	AST_FLUSH_FIRST: assert property (s_q.chg == io_pass_pkg::CHG_PEND && s_q.tx.flush
		|-> !s_q.tx.change ##1 s_q.tx.change) else $error("change not after flush"); // [RULE4]
	AST_FOREIGN_NO_DRIVE: assert property (i_rx.valid && i_rx.src != i_cfg.line_pass_source_addr
		&& i_cfg.line_pass_source_addr != io_pass_pkg::BCAST_ADDR
		|=> (s_q.pass_act & ~$past(s_q.pass_act)) == '0) else $error("foreign sample drove line"); // [RULE5]
	AST_BCAST_PWM: assert property (i_rx.valid && i_rx.amask[0] && !s_q.sleep_s2 && !s_q.sleep_d
		&& i_cfg.line_pass_source_addr == io_pass_pkg::BCAST_ADDR
		|=> s_q.pwm_act[0] && s_q.pwm_a_val == $past(i_rx.analog_input_a))
		else $error("broadcast sample ignored"); // [RULE6]
	AST_PASS_ON_OUTPUT: assert property ((s_q.pass_act & ~s_q.line_oe) == '0)
		else $error("passed line not an output"); // [RULE7]
	AST_TMR_PAUSE: assert property (s_q.sleep_s2 |=> s_q.tmr == $past(s_q.tmr)
		&& s_q.pass_act == $past(s_q.pass_act)) else $error("timer ran in sleep"); // [RULE17]
	AST_PWM_LOW_SLEEP: assert property (s_q.sleep_s2 |=> !s_q.pwm_a && !s_q.pwm_b)
		else $error("pwm high in sleep"); // [RULE18]
	AST_WAKE_PRESET: assert property (s_q.sleep_d && !s_q.sleep_s2 |=> s_q.pwm_act == 2'b00)
		else $error("passed pwm kept on wake"); // [RULE18]
	AST_FOREIGN_EMIT: assert property (i_rx.valid && i_cfg.api_mode
		&& i_rx.src != i_cfg.line_pass_source_addr
		&& i_cfg.line_pass_source_addr != io_pass_pkg::BCAST_ADDR |=> s_q.emit)
		else $error("foreign frame suppressed"); // [RULE13]
	AST_SLEEP_PERIPH: assert property (s_q.sleep_s2 |=> s_q.periph.spi == 4'hf
		&& s_q.periph.other == 2'b00) else $error("peripheral pins wrong in sleep"); // [RULE16]

	COV_CHANGE: cover property (s_q.tx.change);
	COV_FLUSH_THEN_CHANGE: cover property (s_q.tx.flush ##1 s_q.tx.change);
	COV_PASS_EXPIRE: cover property (s_q.pass_act[0] ##1 !s_q.pass_act[0]);

endmodule : io_change_detect_line_passing

`default_nettype wire

// File: logic/io_pass_pkg.sv
// Constants and carrier types for the I/O change detect and line passing block.
// Assumes a single 50 MHz module clock; configuration words come from firmware as levels.
package io_pass_pkg;

	localparam int NL = 14;
	localparam int DW = 10;
	localparam int TW = 8;
	localparam int OVR_LINES = 8;
	localparam logic [2:0] MODE_DIN = 3'h3;
	localparam logic [2:0] MODE_DOUT_LO = 3'h4;
	localparam logic [2:0] MODE_DOUT_HI = 3'h5;
	localparam logic [15:0] BCAST_ADDR = 16'hffff;
	localparam logic [15:0] IVAL_OFF = 16'h0000;
	localparam logic [7:0] SPP_SINGLE = 8'h01;
	// Every general line from the first through the last pass line may be passed
	localparam logic [NL-1:0] PASS_LINES = 14'h3fff;
	localparam int CLK_NS = 20;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int TICK_MS = 100;

	typedef struct packed {
		logic [NL-1:0][2:0] line_mode;
		logic [NL-1:0] change_watch_mask;
		logic [15:0] periodic_sample_interval;
		logic [7:0] samples_per_packet;
		logic [15:0] line_pass_source_addr;
		logic matched_frame_emit_enable;
		logic api_mode;
		logic [TW-1:0] pwm_pass_timeout;
		logic [DW-1:0] pwm_a_preset_duty;
		logic [DW-1:0] pwm_b_preset_duty;
		logic [NL-1:0][TW-1:0] digital_pass_timeout;
		logic [NL-1:0] pull_resistor_enable;
		logic [NL-1:0] pull_direction;
	} cfg_t;

	typedef struct packed {
		logic valid;
		logic [15:0] src;
		logic [NL-1:0] dmask;
		logic [NL-1:0] dval;
		logic [1:0] amask;
		logic [DW-1:0] analog_input_a;
		logic [DW-1:0] analog_input_b;
	} rx_sample_t;

	typedef struct packed {
		logic cts;
		logic [1:0] other;
		logic [3:0] spi;
	} periph_t;

	typedef struct packed {
		logic take;
		logic flush;
		logic change;
	} tx_req_t;

	typedef enum logic {CHG_IDLE, CHG_PEND} chg_state_t;

endpackage : io_pass_pkg
